// ### cssst_map.vh
// Functional notes
// (RL1) A channel starts processing only after both its sample-frequency and interpolation-phase slave registers hold non-zero values.
// (RL2) The channel sample-rate oscillator produces the strobes that pace all channel processing.
// (RL3) A broadcast write to the channel immediate-action register raises the update strobe in every addressed channel at once.
// (RL4) A write setting bit 15 of the top immediate-action word at 0x78 asserts the sync output pin.
// (RL5) A slave device in a cascade treats its hardware update input, fed by the master's sync output, as its start update.
// (RL6) Bit 6 of the main control word at 0xc selects the channel on-line mode used to delay a channel start.
// (RL7) In on-line mode RAM access and oscillators keep running but the input FIFO output is forced to zero.
// (RL8) Before a self test the host resets the device and loads the given configuration, coefficients and gain ramp.
// (RL9) Writing 1 to bit 14 of word 0x78 places the device in self-test mode.
// (RL10) In self-test mode the signature computation begins on a channel 0 update while update-select mask bit 15 is set.
// (RL11) The self-test signature reads back in bits 14 to 3 of word 0x7d.
// (RL12) Bit 15 of word 0x7d is the valid flag and reads 1 only after the test completes.
// (RL13) The valid flag clears on the test mode bit or a channel 0 update and sets when the signature completes.
// (RL14) Selected slave registers load from masters on an update strobe, or 4 clocks after a master write in immediate mode.
// (RL15) The sync output is a single-clock pulse on the device clock for each write that sets the sync bit.
`ifndef CSSST_MAP_VH
`define CSSST_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CSSST_OFS_FREQ 7'h00
`define CSSST_OFS_PHASE 7'h01
`define CSSST_OFS_MAIN 7'h0c
`define CSSST_OFS_MASK 7'h0e
`define CSSST_OFS_IMMED 7'h0f
`define CSSST_OFS_TOP 7'h78
`define CSSST_OFS_SIG 7'h7d
`define CSSST_CH_STRIDE_SH 5
`define CSSST_OFS_BCAST 7'h1f
`define CSSST_TOP_SH 3
`define CSSST_TOP_SPACE 4'hf
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSSST_TOP_SYNC 15
`define CSSST_TOP_TEST 14
`define CSSST_MAIN_IMMED 15
`define CSSST_MAIN_ONLINE 6
`define CSSST_MAIN_HWUPD 5
`define CSSST_IMMED_SWUPD 0
`define CSSST_MASK_SELFTEST 15
`define CSSST_MASK_FREQ 1
`define CSSST_MASK_PHASE 2
`define CSSST_SIG_VALID 15
`define CSSST_SIG_HI 14
`define CSSST_SIG_LO 3
// ----------------------------------------
// Timing and reset values
// ----------------------------------------
`define CSSST_IMMED_DLY 3'h4
`define CSSST_SIG_LEN 8'hff
`define CSSST_SIG_SEED 12'h5a5
`define CSSST_ZERO16 16'h0000
`endif

// ### cssst_chan.v
`timescale 1ns/100ps
`include "cssst_map.vh"
module cssst_chan #(
    parameter NCO_W = 16
) (
    input wire core_clk,
    input wire reset_n,
    input wire wr_main,
    input wire wr_mask,
    input wire wr_freq,
    input wire wr_phase,
    input wire [15:0] wdata,
    input wire update,
    input wire [15:0] fifo_in,
    output reg [15:0] main_r,
    output reg [15:0] mask_r,
    output reg running_r,
    output reg proc_strobe_r,
    output reg [15:0] fifo_out_r
);
    reg [15:0] freq_m_r;
    reg [15:0] phase_m_r;
    reg [15:0] freq_s_r;
    reg [15:0] phase_s_r;
    reg [2:0] fdly_r;
    reg [2:0] pdly_r;
    reg [NCO_W-1:0] nco_r;
    wire [NCO_W:0] nco_sum;
    wire imm;
    assign imm = main_r[`CSSST_MAIN_IMMED];
    assign nco_sum = {1'b0, nco_r} + {1'b0, freq_s_r[NCO_W-1:0]};
    // ----------------------------------------
    // Master and slave registers
    // ----------------------------------------
    // The immediate path counts its own delay so a back-to-back write restarts it.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_r <= `CSSST_ZERO16;
            mask_r <= `CSSST_ZERO16;
            freq_m_r <= `CSSST_ZERO16;
            phase_m_r <= `CSSST_ZERO16;
            freq_s_r <= `CSSST_ZERO16;
            phase_s_r <= `CSSST_ZERO16;
            fdly_r <= 3'h0;
            pdly_r <= 3'h0;
        end else begin
            if (wr_main) main_r <= wdata;
            if (wr_mask) mask_r <= wdata;
            if (wr_freq) freq_m_r <= wdata;
            if (wr_phase) phase_m_r <= wdata;
            if (wr_freq && imm) fdly_r <= `CSSST_IMMED_DLY;
            else if (fdly_r != 3'h0) fdly_r <= fdly_r - 3'h1;
            if (wr_phase && imm) pdly_r <= `CSSST_IMMED_DLY;
            else if (pdly_r != 3'h0) pdly_r <= pdly_r - 3'h1;
            if ((imm && fdly_r == 3'h1) ||
                (!imm && update && mask_r[`CSSST_MASK_FREQ])) begin
                freq_s_r <= freq_m_r; // [RL14]
            end
            if ((imm && pdly_r == 3'h1) ||
                (!imm && update && mask_r[`CSSST_MASK_PHASE])) begin
                phase_s_r <= phase_m_r; // [RL14]
            end
        end
    end
    // ----------------------------------------
    // Sample-rate oscillator and data path
    // ----------------------------------------
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            running_r <= 1'b0;
            nco_r <= {NCO_W{1'b0}};
            proc_strobe_r <= 1'b0;
            fifo_out_r <= `CSSST_ZERO16;
        end else begin
            running_r <= (freq_s_r != `CSSST_ZERO16) && (phase_s_r != `CSSST_ZERO16); // [RL1]
            // Oscillator keeps running in on-line mode.
            nco_r <= nco_sum[NCO_W-1:0]; // [RL7]
            proc_strobe_r <= running_r && nco_sum[NCO_W]; // [RL2]
            if (main_r[`CSSST_MAIN_ONLINE] || !running_r) begin
                fifo_out_r <= `CSSST_ZERO16; // [RL6] [RL7]
            end else if (nco_sum[NCO_W]) begin
                fifo_out_r <= fifo_in;
            end
        end
    end
endmodule // cssst_chan

// ### cssst_sig.v
`timescale 1ns/100ps
`include "cssst_map.vh"
module cssst_sig (
    input wire core_clk,
    input wire reset_n,
    input wire start,
    input wire clr,
    input wire [15:0] data_in,
    output reg [11:0] sig_r,
    output reg valid_r,
    output reg busy_r
);
    reg [7:0] cnt_r;
    wire fb;
    assign fb = sig_r[11] ^ sig_r[5] ^ sig_r[3] ^ sig_r[0];
    // ----------------------------------------
    // Signature register
    // ----------------------------------------
    // A start restarts the compression even mid-run, so a clear never hides a set.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sig_r <= 12'h000;
            valid_r <= 1'b0;
            busy_r <= 1'b0;
            cnt_r <= 8'h00;
        end else if (start) begin
            sig_r <= `CSSST_SIG_SEED; // [RL10]
            busy_r <= 1'b1;
            cnt_r <= `CSSST_SIG_LEN;
            valid_r <= 1'b0; // [RL13]
        end else if (busy_r) begin
            sig_r <= {sig_r[10:0], fb} ^ data_in[11:0];
            cnt_r <= cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
                busy_r <= 1'b0;
                valid_r <= 1'b1; // [RL12] [RL13]
            end
        end else if (clr) begin
            valid_r <= 1'b0; // [RL13]
        end
    end
endmodule // cssst_sig

// ### cssst_top.v
`timescale 1ns/100ps
`include "cssst_map.vh"
module cssst_top #(
    parameter NCH = 4,
    parameter NCO_W = 16
) (
    input wire core_clk,
    input wire reset_n,
    input wire host_cs_n,
    input wire host_wr_n,
    input wire host_rd_n,
    input wire [6:0] host_addr,
    input wire [15:0] host_data_in,
    output reg [15:0] host_data_out,
    output wire host_data_oe,
    input wire hw_update_input,
    output reg sync_out_pin,
    input wire [16*NCH-1:0] fifo_data_in,
    output wire [16*NCH-1:0] fifo_data_out,
    output wire [NCH-1:0] proc_strobe,
    output wire [NCH-1:0] chan_running
);
    reg wr_d_r;
    reg test_mode_r;
    wire wr_pulse;
    wire top_wr;
    wire [1:0] ch_sel;
    wire bcast;
    wire top_sp;
    wire [NCH-1:0] ch_hit;
    wire [NCH-1:0] upd;
    wire [16*NCH-1:0] main_v;
    wire [16*NCH-1:0] mask_v;
    wire [11:0] sig;
    wire sig_valid;
    wire ch0_upd;
    // Offset match inside a channel window; the top words share the last window.
    function ofs_is;
        input [6:0] a;
        input [6:0] o;
        begin
            ofs_is = (a[`CSSST_CH_STRIDE_SH-1:0] == o[`CSSST_CH_STRIDE_SH-1:0]) &&
                (a[6:`CSSST_TOP_SH] != `CSSST_TOP_SPACE);
        end
    endfunction
    // ----------------------------------------
    // Host write decode
    // ----------------------------------------
    // The write is taken on the rising edge of the write strobe, once per access.
    assign wr_pulse = !host_cs_n && host_wr_n && !wr_d_r;
    assign top_wr = wr_pulse && host_addr == `CSSST_OFS_TOP;
    assign ch_sel = host_addr[`CSSST_CH_STRIDE_SH+1:`CSSST_CH_STRIDE_SH];
    assign top_sp = host_addr[6:`CSSST_TOP_SH] == `CSSST_TOP_SPACE;
    assign bcast = ofs_is(host_addr, `CSSST_OFS_BCAST);
    assign host_data_oe = !host_cs_n && !host_rd_n;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_d_r <= 1'b1;
            sync_out_pin <= 1'b0;
            test_mode_r <= 1'b0;
        end else begin
            wr_d_r <= host_cs_n || host_wr_n;
            sync_out_pin <= top_wr && host_data_in[`CSSST_TOP_SYNC]; // [RL4] [RL15]
            if (top_wr) test_mode_r <= host_data_in[`CSSST_TOP_TEST]; // [RL9]
        end
    end
    // ----------------------------------------
    // Channels
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            wire hit_w;
            wire [15:0] m_w;
            // Broadcast addresses reach every channel in the same cycle.
            assign hit_w = wr_pulse && !top_sp && (bcast || ch_sel == g); // [RL3]
            assign ch_hit[g] = hit_w;
            assign m_w = main_v[16*g+15:16*g];
            assign upd[g] = (hit_w && (ofs_is(host_addr, `CSSST_OFS_IMMED) || bcast) &&
                host_data_in[`CSSST_IMMED_SWUPD]) || // [RL3]
                (m_w[`CSSST_MAIN_HWUPD] && hw_update_input); // [RL5]
            cssst_chan #(.NCO_W(NCO_W)) u_ch (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .wr_main(hit_w && ofs_is(host_addr, `CSSST_OFS_MAIN)),
                .wr_mask(hit_w && ofs_is(host_addr, `CSSST_OFS_MASK)),
                .wr_freq(hit_w && ofs_is(host_addr, `CSSST_OFS_FREQ)),
                .wr_phase(hit_w && ofs_is(host_addr, `CSSST_OFS_PHASE)),
                .wdata(host_data_in),
                .update(upd[g]),
                .fifo_in(fifo_data_in[16*g+15:16*g]),
                .main_r(main_v[16*g+15:16*g]),
                .mask_r(mask_v[16*g+15:16*g]),
                .running_r(chan_running[g]),
                .proc_strobe_r(proc_strobe[g]),
                .fifo_out_r(fifo_data_out[16*g+15:16*g])
            );
        end
    endgenerate
    // ----------------------------------------
    // Self test
    // ----------------------------------------
    assign ch0_upd = upd[0];
    cssst_sig u_sig (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .start(test_mode_r && ch0_upd && mask_v[`CSSST_MASK_SELFTEST]), // [RL10]
        .clr((top_wr && host_data_in[`CSSST_TOP_TEST]) || ch0_upd), // [RL13]
        .data_in(fifo_data_out[15:0]),
        .sig_r(sig),
        .valid_r(sig_valid),
        .busy_r()
    );
    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            host_data_out <= `CSSST_ZERO16;
        end else if (host_addr == `CSSST_OFS_SIG) begin
            host_data_out <= {sig_valid, sig, 3'h0}; // [RL11] [RL12]
        end else if (host_addr == `CSSST_OFS_TOP) begin
            host_data_out <= {1'b0, test_mode_r, 14'h0000};
        end else if (ofs_is(host_addr, `CSSST_OFS_MAIN)) begin
            host_data_out <= main_v[16*ch_sel+:16];
        end else if (ofs_is(host_addr, `CSSST_OFS_MASK)) begin
            host_data_out <= mask_v[16*ch_sel+:16];
        end else begin
            host_data_out <= `CSSST_ZERO16;
        end
    end
endmodule // cssst_top

// ### cssst_asserts.sv
`timescale 1ns/100ps
// --------
// Host port and start-up checks
// --------
module cssst_asserts #(
    parameter NCH = 4
) (
    input wire core_clk,
    input wire reset_n,
    input wire host_cs_n,
    input wire host_wr_n,
    input wire host_rd_n,
    input wire [6:0] host_addr,
    input wire [15:0] host_data_in,
    input wire [15:0] host_data_out,
    input wire sync_out_pin,
    input wire [16*NCH-1:0] fifo_data_out,
    input wire [NCH-1:0] proc_strobe,
    input wire [NCH-1:0] chan_running
);
    reg wl_r;
    reg fnz_r;
    reg pnz_r;
    reg onl_r;
    wire take = !host_cs_n && host_wr_n && wl_r;
    wire rd_sig = !host_cs_n && !host_rd_n && host_addr == 7'h7d;
    wire idle = !chan_running[0];
    // Masters are shadowed here because a start can never precede non-zero masters.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wl_r <= 1'b0;
            fnz_r <= 1'b0;
            pnz_r <= 1'b0;
            onl_r <= 1'b0;
        end else begin
            wl_r <= !host_cs_n && !host_wr_n;
            if (take && host_addr == 7'h00) fnz_r <= |host_data_in;
            if (take && host_addr == 7'h01) pnz_r <= |host_data_in;
            if (take && host_addr == 7'h0c) onl_r <= host_data_in[6];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence sig_rd_s; rd_sig [*2]; endsequence
    sequence upd_s; take && host_addr == 7'h0f && host_data_in[0]; endsequence
    sequence tst_s; take && host_addr == 7'h78 && host_data_in[14]; endsequence
    sync_pulse_a: assert property (sync_out_pin |=> !sync_out_pin)
        else $error("sync output wider than one cycle");
    sync_launch_a: assert property (take && host_addr == 7'h78 && host_data_in[15] |=> sync_out_pin)
        else $error("sync output missing after sync write");
    sync_cause_a: assert property (sync_out_pin |-> $past(take && host_addr == 7'h78 && host_data_in[15]))
        else $error("sync output without sync write");
    online_zero_a: assert property (onl_r && $past(onl_r) |-> fifo_data_out[15:0] == 16'h0000)
        else $error("fifo data passes in on-line mode");
    idle_zero_a: assert property (idle && $past(idle) |-> fifo_data_out[15:0] == 16'h0000)
        else $error("fifo data passes while stopped");
    idle_strobe_a: assert property (idle && $past(idle) |-> !proc_strobe[0])
        else $error("strobe while stopped");
    run_gate_a: assert property (!(fnz_r && pnz_r) |-> idle)
        else $error("running with a zero master");
    upd_clear_a: assert property (upd_s ##[1:4] sig_rd_s |-> !host_data_out[15])
        else $error("valid flag not cleared by update");
    test_clear_a: assert property (tst_s ##[1:4] sig_rd_s |-> !host_data_out[15])
        else $error("valid flag not cleared by test mode");
endmodule // cssst_asserts
bind cssst_top cssst_asserts #(.NCH(NCH)) chk (.core_clk, .reset_n, .host_cs_n, .host_wr_n,
    .host_rd_n, .host_addr, .host_data_in, .host_data_out, .sync_out_pin, .fifo_data_out,
    .proc_strobe, .chan_running);

// ### cssst_host.sv
`timescale 1ns/100ps
// --------
// Host processor and cascaded slave
// --------
module cssst_host (
    input wire core_clk,
    input wire sync_out_pin,
    input wire [15:0] host_data_out,
    output reg host_cs_n,
    output reg host_wr_n,
    output reg host_rd_n,
    output reg [6:0] host_addr,
    output reg [15:0] host_data_in,
    output reg hw_update_input,
    output reg rd_stb,
    output reg [15:0] rd_val
);
    initial begin
        host_cs_n = 1'b1;
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        host_addr = 7'h00;
        host_data_in = 16'h0000;
        hw_update_input = 1'b0;
        rd_stb = 1'b0;
        rd_val = 16'h0000;
    end
    // The slave sees the master's sync one board flop later.
    always @(posedge core_clk) hw_update_input <= sync_out_pin;
    task wr(input [6:0] a, input [15:0] d);
        begin
            @(posedge core_clk);
            host_cs_n <= 1'b0;
            host_wr_n <= 1'b0;
            host_addr <= a;
            host_data_in <= d;
            @(posedge core_clk);
            host_wr_n <= 1'b1;
            @(posedge core_clk);
            host_cs_n <= 1'b1;
            // A released bus must not look like it still holds the data.
            host_data_in <= ~d;
        end
    endtask
    task rd(input [6:0] a, input chk, output [15:0] v);
        begin
            @(posedge core_clk);
            host_cs_n <= 1'b0;
            host_rd_n <= 1'b0;
            host_addr <= a;
            repeat (2) @(posedge core_clk);
            v = host_data_out;
            rd_val <= v;
            rd_stb <= chk;
            host_cs_n <= 1'b1;
            host_rd_n <= 1'b1;
            @(posedge core_clk);
            rd_stb <= 1'b0;
        end
    endtask
endmodule // cssst_host

// ### tb_top.sv
`timescale 1ns/100ps
module tb_top;
    reg core_clk = 1'b0;
    reg reset_n = 1'b0;
    reg [63:0] fifo_data_in = 64'h0;
    integer seed = 32'hb139de3b;
    integer err_total = 0;
    integer tests_run = 0;
    integer cyc = 0;
    integer sq = 0;
    integer i;
    reg [15:0] v;
    reg [31:0] e;
    reg [31:0] rq[$];
    wire cs_n, wr_n, rd_n, hw_upd, sync, rd_stb, oe;
    wire [6:0] addr;
    wire [15:0] din, dout, rd_val;
    wire [63:0] fout;
    wire [3:0] strb, run;
    wire [1:0] obs = {strb[0], run[0]};
    cssst_top uut (.core_clk(core_clk), .reset_n(reset_n), .host_cs_n(cs_n), .host_wr_n(wr_n),
        .host_rd_n(rd_n), .host_addr(addr), .host_data_in(din), .host_data_out(dout),
        .host_data_oe(oe), .hw_update_input(hw_upd), .sync_out_pin(sync),
        .fifo_data_in(fifo_data_in), .fifo_data_out(fout), .proc_strobe(strb), .chan_running(run));
    cssst_host h (.core_clk(core_clk), .sync_out_pin(sync), .host_data_out(dout),
        .host_cs_n(cs_n), .host_wr_n(wr_n), .host_rd_n(rd_n), .host_addr(addr),
        .host_data_in(din), .hw_update_input(hw_upd), .rd_stb(rd_stb), .rd_val(rd_val));
    initial forever #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) fifo_data_in <= {$random(seed), $random(seed)};
    task close_out;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, err_total);
            if (err_total == 0 && tests_run > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    task cmp_bit(input got, input x);
        begin
            tests_run = tests_run + 1;
            if (got !== x) begin
                err_total = err_total + 1;
                $display("[FAIL] %0t bit got %b exp %b", $time, got, x);
            end
        end
    endtask
    task cmp_rd(input [15:0] got, input [15:0] m, input [15:0] x);
        begin
            tests_run = tests_run + 1;
            if ((got & m) !== x) begin
                err_total = err_total + 1;
                $display("[FAIL] %0t read got %h exp %h", $time, got, x);
            end
        end
    endtask
    task exp_rd(input [6:0] a, input [15:0] m, input [15:0] x);
        begin
            rq.push_back({m, x});
            h.rd(a, 1'b1, v);
        end
    endtask
    task do_rst;
        begin
            reset_n <= 1'b0;
            repeat (12) @(posedge core_clk);
            reset_n <= 1'b1;
        end
    endtask
    task wait_obs(input integer k, input x);
        begin
            for (i = 0; i < 40 && obs[k] !== x; i = i + 1) @(posedge core_clk);
            cmp_bit(obs[k], x);
        end
    endtask
    // A high frequency word keeps the strobe period within a few clocks.
    task cfg(input [15:0] mk, input [15:0] mn);
        begin
            h.wr(7'h00, 16'h8000 | $random(seed));
            h.wr(7'h01, 16'h0001 | $random(seed));
            h.wr(7'h0e, mk);
            h.wr(7'h0c, mn);
        end
    endtask
    task sync_wr(input [15:0] d);
        begin
            h.wr(7'h78, d);
            if (d[15]) sq = sq + 1;
        end
    endtask
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (rd_stb === 1'b1) begin
            e = rq.pop_front();
            cmp_rd(rd_val, e[31:16], e[15:0]);
        end
        if (sync === 1'b1) begin
            cmp_bit(sq > 0, 1'b1);
            sq = sq - 1;
        end
        if (cyc == 30000) begin
            err_total = err_total + 1;
            $display("[FAIL] %0t run timed out", $time);
            close_out;
        end
    end
    initial begin
        do_rst;
        cmp_bit(run[0], 1'b0);
        sync_wr(16'h8000);
        sync_wr(16'h0000);
        exp_rd(7'h7d, 16'h8000, 16'h0000);
        exp_rd(7'h18, 16'hffff, 16'h0000);
        $display("test sync done");
        cfg(16'h0006, 16'h0040);
        exp_rd(7'h0c, 16'hffff, 16'h0040);
        cmp_bit(run[0], 1'b0);
        h.wr(7'h0f, 16'h0001);
        wait_obs(0, 1'b1);
        wait_obs(1, 1'b1);
        cmp_bit(fout[15:0] == 16'h0000, 1'b1);
        $display("test online done");
        do_rst;
        cfg(16'h0006, 16'h0020);
        sync_wr(16'h8000);
        wait_obs(0, 1'b1);
        $display("test cascade done");
        do_rst;
        cfg(16'h0006, 16'h0000);
        h.wr(7'h20, 16'h8000 | $random(seed));
        h.wr(7'h21, 16'h0001 | $random(seed));
        h.wr(7'h2e, 16'h0006);
        h.wr(7'h1f, 16'h0001);
        cmp_bit(run[1], 1'b0);
        wait_obs(0, 1'b1);
        cmp_bit(run[1], 1'b1);
        $display("test broadcast done");
        do_rst;
        cfg(16'h0000, 16'h8000);
        h.wr(7'h00, 16'h8000 | $random(seed));
        h.wr(7'h01, 16'h0001 | $random(seed));
        repeat (5) @(posedge core_clk);
        cmp_bit(run[0], 1'b0);
        @(posedge core_clk);
        cmp_bit(run[0], 1'b1);
        $display("test immediate done");
        do_rst;
        cfg(16'h8006, 16'h0000);
        h.wr(7'h78, 16'h4000);
        h.wr(7'h0f, 16'h0001);
        exp_rd(7'h7d, 16'h8000, 16'h0000);
        v = 16'h0000;
        for (i = 0; i < 200 && v[15] !== 1'b1; i = i + 1) h.rd(7'h7d, 1'b0, v);
        exp_rd(7'h7d, 16'h8007, 16'h8000);
        h.wr(7'h78, 16'h4000);
        exp_rd(7'h7d, 16'h8000, 16'h0000);
        $display("test self test done");
        cmp_bit(sq == 0, 1'b1);
        close_out;
    end
endmodule // tb_top
